/* adcsc_pkg.sv */
// Package: register map, field positions, reset values, timing counts.
package adcsc_pkg;
    // ---------------------------------------------------------------
    // Bus widths
    // ---------------------------------------------------------------
    localparam int ADDR_W = 8;  // Byte offset width
    localparam int DATA_W = 16; // Read data width
    localparam int RAW_W  = 10; // Raw converter result width

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADR_PWR  = 8'h62; // power_irq_control
    localparam logic [7:0] ADR_SEQ  = 8'h63; // sequence_debug_control
    localparam logic [7:0] ADR_CLK  = 8'h64; // clock_sample_control
    localparam logic [7:0] ADR_CTL  = 8'h65; // sequence_control
    localparam logic [7:0] ADR_STAT = 8'h66; // conversion_status_reg
    localparam logic [7:0] ADR_RES0 = 8'h70; // First result, 8 in a row

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int PWR_ON_BIT = 7; // analog_power_on
    localparam int FFC_BIT    = 6; // fast_flag_clear
    localparam int HIW_BIT    = 5; // halt_in_wait
    localparam int JR_BIT     = 4; // justify_right
    localparam int IRQEN_BIT  = 1; // seq_done_irq_enable
    localparam int IRQF_BIT   = 0; // seq_done_irq_flag, read only
    localparam int S1C_BIT    = 3; // single_conversion_length
    localparam int FIFO_BIT   = 2; // Result counter FIFO mode
    localparam int FRZH_BIT   = 1; // debug_halt_select_hi
    localparam int FRZL_BIT   = 0; // debug_halt_select_lo
    localparam int RES_BIT    = 7; // resolution_select
    localparam int S8C_BIT    = 6; // eight_conversion_length
    localparam int SCAN_BIT   = 5; // Continuous sequences
    localparam int SCF_BIT    = 7; // sequence_done_flag in status
    localparam int CCF_LSB    = 8; // conversion_done_flag field

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam logic [7:0] SEQ_RST = 8'h00;
    localparam logic [7:0] CLK_RST = 8'h01;
    localparam logic [7:0] CTL_RST = 8'h00;

    // ---------------------------------------------------------------
    // Freeze codes, sequence lengths minus one, conversion cycles
    // ---------------------------------------------------------------
    localparam logic [1:0] FRZ_FINISH = 2'h2;
    localparam logic [1:0] FRZ_NOW    = 2'h3;
    localparam logic [2:0] LEN_ONE    = 3'h0;
    localparam logic [2:0] LEN_FOUR   = 3'h3;
    localparam logic [2:0] LEN_EIGHT  = 3'h7;
    localparam logic [3:0] CONV8_CYC  = 4'hA;
    localparam logic [3:0] CONV10_CYC = 4'hC;

    // Sequencer states
    typedef enum logic [0:0] {SQ_IDLE, SQ_RUN} adcsc_state_t;
endpackage : adcsc_pkg

/* adcsc_top.sv */
// Converter sequence control: registers, flags, sequencer, results.
//
// The strobed register port is this design's own decision.

// What this block does
// - Control 2/3 writes never start; only a power-off write aborts
// - Power bit cleared aborts and powers down
// - Normal clear: status read then result read
// - Fast clear: any result access clears flag
// - Normal: new sequence clears sequence-done
// - Fast: first result read clears sequence-done
// - Halt-in-wait stops and powers down
// - Leaving wait resumes without restarting
// - Ten-bit result at bits 6-15 or 0-9
// - Eight-bit result in high or low byte
// - Sequence end raises interrupt, results ready
// - Interrupt flag held until its clear events
// - Interrupt flag ignores all writes except a start
// - Reset clears pending interrupt
// - Single length unless eight length set
// - FIFO counter runs on and wraps
// - Counter zeroed at reset, normal start, end
// - Status shows the result counter
// - Freeze field picks breakpoint response
// - Debug release resumes exactly
// - Clock register write restarts sequence
// - Resolution bit picks eight or ten bits
// - Start clears sequence and conversion flags
module adcsc_top
    import adcsc_pkg::*;
#(
    parameter int N_RESULTS = 8 // Result file depth
) (
    input  wire logic              clk_i,         // System clock
    input  wire logic              srst_i,        // Sync reset, high
    input  wire logic [ADDR_W-1:0] addr_i,        // Register offset
    input  wire logic [7:0]        wdata_i,       // Write data
    input  wire logic              wr_i,          // Write strobe
    input  wire logic              rd_i,          // Read strobe
    output logic      [DATA_W-1:0] rdata_o,       // Read data
    input  wire logic              wait_i,        // Processor in wait
    input  wire logic              debug_i,       // background_debug on
    input  wire logic [RAW_W-1:0]  conv_data_i,   // Converter result
    output logic                   irq_o,         // Sequence interrupt
    output logic                   analog_en_o,   // Analog powered
    output logic                   busy_o         // Sequence running
);
    // ---------------------------------------------------------------
    // Elaboration check
    // ---------------------------------------------------------------
    // The counter and index fields are three bits wide
    if (N_RESULTS != 8) $error("N_RESULTS must be 8");

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic [7:0]       pwr_reg;       // power_irq_control
    logic [7:0]       seq_reg;       // sequence_debug_control
    logic [7:0]       clk_reg;       // clock_sample_control
    logic [7:0]       ctl_reg;       // sequence_control
    logic             irqf_reg;      // seq_done_irq_flag
    logic             scf_reg;       // sequence_done_flag
    logic [7:0]       ccf_reg;       // conversion_done_flag per entry
    logic [7:0]       armed_reg;     // Flag seen by a status read
    logic [RAW_W-1:0] res_reg [8];   // Raw results
    logic [2:0]       ptr_reg;       // Result counter
    logic [2:0]       cnt_reg;       // Conversions done this sequence
    logic [2:0]       len_reg;       // Sequence length minus one
    logic [3:0]       phase_reg;     // Cycle within a conversion
    adcsc_state_t     state_reg;     // Sequencer state
    logic [DATA_W-1:0] rdata_reg;    // Read data flop
    logic             irq_reg;       // Interrupt output flop
    logic             aen_reg;       // Analog enable flop
    logic             busy_reg;      // Busy flop

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    logic       wr_pwr;   // Write power_irq_control
    logic       wr_seq;   // Write sequence_debug_control
    logic       wr_clk;   // Write clock_sample_control
    logic       wr_ctl;   // Write sequence_control
    logic       rd_stat;  // Read status
    logic       res_hit;  // Address is in the result file
    logic       rd_res;   // Read of a result
    logic       acc_res;  // Read or write of a result
    logic [2:0] res_idx;  // Result index

    assign wr_pwr  = wr_i && (addr_i == ADR_PWR);
    assign wr_seq  = wr_i && (addr_i == ADR_SEQ);
    assign wr_clk  = wr_i && (addr_i == ADR_CLK);
    assign wr_ctl  = wr_i && (addr_i == ADR_CTL);
    assign rd_stat = rd_i && (addr_i == ADR_STAT);
    assign res_hit = (addr_i[7:3] == ADR_RES0[7:3]);
    assign rd_res  = rd_i && res_hit;
    assign acc_res = (rd_i || wr_i) && res_hit;
    assign res_idx = addr_i[2:0];

    // ---------------------------------------------------------------
    // Control terms
    // ---------------------------------------------------------------
    logic       ffc;        // Fast flag clearing
    logic       fifo;       // Result counter free running
    logic [1:0] frz;        // Debug freeze select
    logic       start;      // New sequence
    logic       power_off;  // Power bit being cleared
    logic       wait_halt;  // Halted by wait
    logic       stall;      // Sequencer held this cycle
    logic [3:0] conv_top;   // Last phase of a conversion
    logic       done_conv;  // Conversion completes now
    logic       seq_end;    // Sequence completes now
    logic       s8c_new;    // Eight length bit seen at start
    logic [7:0] clr_ccf;    // Software clear per entry

    assign ffc  = pwr_reg[FFC_BIT];
    assign fifo = seq_reg[FIFO_BIT];
    assign frz  = {seq_reg[FRZH_BIT], seq_reg[FRZL_BIT]};
    // Control 2/3 writes stay out of this term
    assign start = (wr_clk || wr_ctl) && pwr_reg[PWR_ON_BIT];
    assign power_off = wr_pwr && !wdata_i[PWR_ON_BIT];
    assign wait_halt = wait_i && pwr_reg[HIW_BIT];
    // Finish mode stops only on a conversion boundary
    assign stall = wait_halt
                 || (debug_i && (frz == FRZ_NOW))
                 || (debug_i && (frz == FRZ_FINISH)
                     && (phase_reg == 4'h0));
    // Resolution chooses conversion length
    assign conv_top = clk_reg[RES_BIT] ? CONV10_CYC - 4'h1
                                       : CONV8_CYC - 4'h1;
    assign done_conv = (state_reg == SQ_RUN) && !stall
                     && (phase_reg == conv_top);
    assign seq_end = done_conv && (cnt_reg == len_reg);
    assign s8c_new = wr_ctl ? wdata_i[S8C_BIT] : ctl_reg[S8C_BIT];

    // ---------------------------------------------------------------
    // Control register writes
    // ---------------------------------------------------------------
    // The interrupt flag is not stored here, so only a start write can reach it
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pwr_reg <= PWR_RST;
            seq_reg <= SEQ_RST;
            clk_reg <= CLK_RST;
            ctl_reg <= CTL_RST;
        end
        else
        begin
            if (wr_pwr)
            begin
                pwr_reg <= {wdata_i[7:1], 1'b0};
            end
            if (wr_seq)
            begin
                seq_reg <= wdata_i;
            end
            if (wr_clk)
            begin
                clk_reg <= wdata_i;
            end
            if (wr_ctl)
            begin
                ctl_reg <= wdata_i;
            end
        end
    end

    // ---------------------------------------------------------------
    // Sequencer state
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_reg <= SQ_IDLE;
        end
        else if (power_off)
        begin
            // Abort whatever runs
            state_reg <= SQ_IDLE;
        end
        else if (start)
        begin
            state_reg <= SQ_RUN;
        end
        else if (seq_end && !ctl_reg[SCAN_BIT])
        begin
            state_reg <= SQ_IDLE;
        end
    end

    // ---------------------------------------------------------------
    // Conversion phase counter
    // ---------------------------------------------------------------
    // A stall freezes the phase, so release resumes in place
    always_ff @(posedge clk_i)
    begin
        if (srst_i || start || power_off)
        begin
            phase_reg <= 4'h0;
        end
        else if ((state_reg == SQ_RUN) && !stall)
        begin
            phase_reg <= done_conv ? 4'h0 : phase_reg + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // Sequence length and progress
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            len_reg <= LEN_FOUR;
            cnt_reg <= 3'h0;
        end
        else if (start)
        begin
            cnt_reg <= 3'h0;
            // Eight length wins over single length
            if (s8c_new)
            begin
                len_reg <= LEN_EIGHT;
            end
            else if (seq_reg[S1C_BIT])
            begin
                len_reg <= LEN_ONE;
            end
            else
            begin
                len_reg <= LEN_FOUR;
            end
        end
        else if (done_conv)
        begin
            cnt_reg <= seq_end ? 3'h0 : cnt_reg + 3'h1;
        end
    end

    // ---------------------------------------------------------------
    // Result counter
    // ---------------------------------------------------------------
    // Three-bit counter wraps at the end of the file by itself
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ptr_reg <= 3'h0;
        end
        else if (start && !fifo)
        begin
            ptr_reg <= 3'h0;
        end
        else if (done_conv)
        begin
            if (seq_end && !fifo)
            begin
                ptr_reg <= 3'h0;
            end
            else
            begin
                ptr_reg <= ptr_reg + 3'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Per-entry results and conversion flags
    // ---------------------------------------------------------------
    for (genvar i = 0; i < 8; i++)
    begin : g_entry
        // Normal needs a prior status read, fast needs none
        assign clr_ccf[i] = ccf_reg[i] && (res_idx == i)
                          && (ffc ? acc_res
                                  : (rd_res && armed_reg[i]));

        // Result capture
        always_ff @(posedge clk_i)
        begin
            if (srst_i)
            begin
                res_reg[i] <= '0;
            end
            else if (done_conv && (ptr_reg == i))
            begin
                res_reg[i] <= conv_data_i;
            end
        end

        // Flag: hardware set wins over every clear
        always_ff @(posedge clk_i)
        begin
            if (srst_i)
            begin
                ccf_reg[i] <= 1'b0;
            end
            else if (done_conv && (ptr_reg == i))
            begin
                ccf_reg[i] <= 1'b1;
            end
            else if (start || clr_ccf[i])
            begin
                ccf_reg[i] <= 1'b0;
            end
        end

        // Status read arms only flags that are set at that moment
        always_ff @(posedge clk_i)
        begin
            if (srst_i)
            begin
                armed_reg[i] <= 1'b0;
            end
            else if (rd_stat)
            begin
                armed_reg[i] <= ccf_reg[i];
            end
            else if (start || clr_ccf[i])
            begin
                armed_reg[i] <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Sequence-done flag
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            scf_reg <= 1'b0;
        end
        else if (seq_end)
        begin
            scf_reg <= 1'b1;
        end
        else if (start)
        begin
            scf_reg <= 1'b0;
        end
        else if (ffc && rd_res)
        begin
            scf_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Sequence interrupt flag
    // ---------------------------------------------------------------
    // Results are already stored when the flag rises
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            irqf_reg <= 1'b0;
        end
        else if (seq_end)
        begin
            irqf_reg <= 1'b1;
        end
        // A fast-mode result write clears its entry, not this flag
        else if (start || (rd_res && (clr_ccf != 8'h00)))
        begin
            irqf_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Output flops
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            irq_reg  <= 1'b0;
            aen_reg  <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            irq_reg  <= irqf_reg && pwr_reg[IRQEN_BIT];
            // Wait halt drops analog power, registers are kept
            aen_reg  <= pwr_reg[PWR_ON_BIT] && !wait_halt;
            busy_reg <= (state_reg == SQ_RUN);
        end
    end

    // ---------------------------------------------------------------
    // Result formatting
    // ---------------------------------------------------------------
    function automatic logic [15:0] fmt(input logic [RAW_W-1:0] r,
                                        input logic r10,
                                        input logic jr);
        logic [15:0] v;
        v = 16'h0000;
        if (r10)
        begin
            v = jr ? {6'h00, r} : {r, 6'h00};
        end
        else
        begin
            v = jr ? {8'h00, r[9:2]} : {r[9:2], 8'h00};
        end
        return v;
    endfunction : fmt

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    // Data stand one cycle after the strobe and read zero otherwise
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !rd_i)
        begin
            rdata_reg <= 16'h0000;
        end
        else if (res_hit)
        begin
            rdata_reg <= fmt(res_reg[res_idx], clk_reg[RES_BIT],
                             pwr_reg[JR_BIT]);
        end
        else
        begin
            unique case (addr_i)
                ADR_PWR:  rdata_reg <= {8'h00, pwr_reg[7:1], irqf_reg};
                ADR_SEQ:  rdata_reg <= {8'h00, seq_reg};
                ADR_CLK:  rdata_reg <= {8'h00, clk_reg};
                ADR_CTL:  rdata_reg <= {8'h00, ctl_reg};
                ADR_STAT: rdata_reg <= {ccf_reg, scf_reg, 4'h0,
                                        ptr_reg};
                default:  rdata_reg <= 16'h0000; // Unmapped
            endcase
        end
    end

    assign rdata_o     = rdata_reg;
    assign irq_o       = irq_reg;
    assign analog_en_o = aen_reg;
    assign busy_o      = busy_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_no_start_ctl23;
        @(posedge clk_i) disable iff (srst_i)
        (wr_seq || (wr_pwr && wdata_i[PWR_ON_BIT]))
            |=> (state_reg == $past(state_reg))
                || $past(seq_end);
    endproperty
    a_no_start_ctl23: assert property (p_no_start_ctl23)
        else $error("control 2/3 write changed sequencer");

    property p_power_off;
        @(posedge clk_i) disable iff (srst_i)
        power_off |=> (state_reg == SQ_IDLE) ##1 !analog_en_o;
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("power off did not abort");

    property p_fast_clear;
        @(posedge clk_i) disable iff (srst_i)
        (acc_res && ffc && (res_idx == 3'h0)
         && !(done_conv && (ptr_reg == 3'h0))) |=> !ccf_reg[0];
    endproperty
    a_fast_clear: assert property (p_fast_clear)
        else $error("fast clear missed");

    property p_scf_start;
        @(posedge clk_i) disable iff (srst_i)
        start |=> (!scf_reg || $past(seq_end))
                  && (ccf_reg == 8'h00 || $past(done_conv));
    endproperty
    a_scf_start: assert property (p_scf_start)
        else $error("start left flags set");

    property p_wait_hold;
        @(posedge clk_i) disable iff (srst_i)
        (wait_halt && !start && !power_off)
            |=> $stable(phase_reg) ##0 !analog_en_o;
    endproperty
    a_wait_hold: assert property (p_wait_hold)
        else $error("wait halt did not hold");

    property p_just_10r;
        @(posedge clk_i) disable iff (srst_i)
        (rd_res && clk_reg[RES_BIT] && pwr_reg[JR_BIT])
            |=> (rdata_o[15:10] == 6'h00);
    endproperty
    a_just_10r: assert property (p_just_10r)
        else $error("right justified data too wide");

    property p_len_eight;
        @(posedge clk_i) disable iff (srst_i)
        (start && s8c_new) |=> (len_reg == LEN_EIGHT);
    endproperty
    a_len_eight: assert property (p_len_eight)
        else $error("eight length did not win");

    property p_ptr_zero;
        @(posedge clk_i) disable iff (srst_i)
        (start && !fifo) |=> (ptr_reg == 3'h0);
    endproperty
    a_ptr_zero: assert property (p_ptr_zero)
        else $error("counter not zeroed");

    property p_irq_out;
        @(posedge clk_i) disable iff (srst_i)
        seq_end && pwr_reg[IRQEN_BIT] |=> ##1 irq_o;
    endproperty
    a_irq_out: assert property (p_irq_out)
        else $error("interrupt output missing");

    c_seq_end: cover property (@(posedge clk_i) disable iff (srst_i)
        seq_end);
    c_frz: cover property (@(posedge clk_i) disable iff (srst_i)
        debug_i && stall && (state_reg == SQ_RUN));
    c_wrap: cover property (@(posedge clk_i) disable iff (srst_i)
        fifo && done_conv && (ptr_reg == 3'h7));
endmodule : adcsc_top

/* adc_sequence_control_test.sv */
// Self-checking bench for the converter sequence control block.
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module adc_sequence_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // Bench signals
    // ----------------
    logic        clk_i = 1'b0;            // 10 MHz clock
    logic        srst_i = 1'b1;           // Reset, 12 cycles
    logic        wr_i = 1'b0;             // Write strobe
    logic        rd_i = 1'b0;             // Read strobe
    logic        wait_i = 1'b0;           // Processor wait
    logic        debug_i = 1'b0;          // Breakpoint active
    logic [7:0]  addr_i = 8'h00;          // Register offset
    logic [7:0]  wdata_i = 8'h00;         // Write data
    logic [9:0]  conv_data_i = 10'h2D5;   // Fixed converter code
    logic [15:0] rdata_o;                 // Read data
    logic        irq_o, analog_en_o, busy_o;
    int          fails = 0, cmp_count = 0, cyc = 0;

    adcsc_top DUT (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .wait_i, .debug_i, .conv_data_i, .irq_o,
        .analog_en_o, .busy_o);

    initial forever #50 clk_i = ~clk_i;

    // Hang guard, about five times the expected run
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            close_out();
        end
    end
    // ----------------
    // Bus and wait tasks
    // ----------------
    task close_out;
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    task w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : w

    // Data stand only in the cycle after the strobe
    task r(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask : r

    task hold(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : hold

    // Busy lags the start by two cycles, so skip ahead first
    task idle;
        hold(3);
        for (int i = 0; i < 200 && busy_o === 1'b1; i++)
            @(posedge clk_i) #1;
        `CHK(busy_o, 1'b0)
    endtask : idle
    // ----------------
    // Scenarios
    // ----------------
    task t_normal;
        r(8'h62, 16'h0000);
        r(8'h64, 16'h0001);
        w(8'h62, 8'h82);
        w(8'h63, 8'h08);
        w(8'h64, 8'h80);
        idle();
        r(8'h70, 16'hB540);
        `CHK(irq_o, 1'b1)
        r(8'h66, 16'h0180);
        w(8'h62, 8'h82);
        r(8'h62, 16'h0083);
        r(8'h70, 16'hB540);
        r(8'h66, 16'h0080);
        `CHK(irq_o, 1'b0)
        w(8'h62, 8'h93);
        r(8'h62, 16'h0092);
        r(8'h70, 16'h02D5);
    endtask : t_normal

    task t_fast;
        w(8'h64, 8'h00);
        r(8'h66, 16'h0000);
        idle();
        r(8'h70, 16'h00B5);
        w(8'h62, 8'hC2);
        r(8'h70, 16'hB500);
        w(8'h65, 8'h40);
        idle();
        r(8'h66, 16'hFF80);
        r(8'h71, 16'hB500);
        r(8'h66, 16'hFD00);
        w(8'h72, 8'h00);
        r(8'h66, 16'hF900);
        `CHK(irq_o, 1'b0)
    endtask : t_fast

    // Counter runs on across sequences, zeroed by a normal start
    task t_fifo;
        w(8'h62, 8'h80);
        w(8'h63, 8'h0C);
        w(8'h65, 8'h00);
        idle();
        w(8'h65, 8'h00);
        idle();
        r(8'h66, 16'h0282);
        w(8'h65, 8'h40);
        idle();
        r(8'h66, 16'hFF82);
        w(8'h63, 8'h08);
        w(8'h65, 8'h00);
        idle();
        r(8'h66, 16'h0180);
    endtask : t_fifo

    task t_halt;
        w(8'h62, 8'hA0);
        w(8'h65, 8'h00);
        wait_i <= 1'b1;
        hold(30);
        `CHK(analog_en_o, 1'b0)
        r(8'h66, 16'h0000);
        wait_i <= 1'b0;
        idle();
        r(8'h66, 16'h0180);
        hold(8);
        w(8'h65, 8'h40);
        w(8'h63, 8'h00);
        w(8'h62, 8'h80);
        #1;
        `CHK(busy_o, 1'b1)
        hold(25);
        w(8'h64, 8'h00);
        r(8'h66, 16'h0000);
        w(8'h62, 8'h00);
        hold(2);
        `CHK(busy_o, 1'b0)
        `CHK(analog_en_o, 1'b0)
    endtask : t_halt

    // Freeze at once, then finish-then-freeze on a four-long run
    task t_freeze;
        w(8'h62, 8'h80);
        w(8'h63, 8'h0B);
        debug_i <= 1'b1;
        w(8'h65, 8'h00);
        hold(30);
        r(8'h66, 16'h0000);
        debug_i <= 1'b0;
        idle();
        r(8'h66, 16'h0180);
        w(8'h63, 8'h02);
        w(8'h65, 8'h00);
        hold(5);
        debug_i <= 1'b1;
        hold(30);
        r(8'h66, 16'h0101);
        debug_i <= 1'b0;
        idle();
        r(8'h66, 16'h0F80);
    endtask : t_freeze

    // Scan runs sequence after sequence until power goes off
    task t_scan;
        w(8'h65, 8'h20);
        hold(60);
        r(8'h66, 16'h0F82);
        w(8'h62, 8'h00);
        hold(2);
        `CHK(busy_o, 1'b0)
    endtask : t_scan

    initial
    begin
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        t_normal();
        t_fast();
        t_fifo();
        t_halt();
        t_freeze();
        t_scan();
        close_out();
    end
endmodule : adc_sequence_control_test
